// ---- design/mpps_pkg.sv ----
// Constants, types and helpers shared by the multiphase pulse sequencer
// ==========================================================================
// What this block does
// - Four channels run by default when neither upper channel output is strapped high.
// - A termination clock, one switching period long, forces each channel low.
// - Four channels terminate in order 4, 3, 2, 1, quarter cycle apart.
// - Channel 4 strapped high with channel 3 not strapped selects three channels, order 3, 2, 1, third-cycle spacing.
// - Channel 3 strapped high selects two channels, half cycle apart.
// - After falling, a channel stays low at least one third cycle.
// - After forced off, output rises when level minus correction crosses the ramp.
// - A high output stays high until its next termination edge.
// - Sample window opens one sixth after fall; closes after third or rise.
// - Each held sample stays unchanged one full cycle until replaced.
// - Held samples feed balancing and the held sample output.
// - Channels disabled by strapping are excluded from sensing and balancing.
// - Average equals sum of active held samples over active channel count.
// - Each active channel forms an error from its held sample versus average.
// - Errors are low-pass filtered and trim each channel's pulse width individually.
package mpps_pkg;

    // ======================================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SW_PERIOD_NS = 1200;
    // Floor of period over clock; 120 cycles, a multiple of twelve
    localparam int SW_PERIOD_CYC = SW_PERIOD_NS / CLK_PERIOD_NS;
    localparam int STRAP_WAIT = 4;

    // ======================================================================
    // Widths
    localparam int NUM_CH = 4;
    localparam int PH_W = 12;
    localparam int SMP_W = 10;
    localparam int LVL_W = 12;
    localparam int ERR_W = SMP_W + 1;
    localparam int RAMP_W = LVL_W + 2;
    localparam int FILT_SHIFT = 3;
    localparam int STRAP_CNT_W = 3;

    // ======================================================================
    // Channel modes
    localparam logic [2:0] MODE_FOUR = 3'h4;
    localparam logic [2:0] MODE_THREE = 3'h3;
    localparam logic [2:0] MODE_TWO = 3'h2;
    localparam logic [NUM_CH-1:0] MASK_FOUR = 4'hf;
    localparam logic [NUM_CH-1:0] MASK_THREE = 4'h7;
    localparam logic [NUM_CH-1:0] MASK_TWO = 4'h3;
    localparam logic [NUM_CH-1:0] OE_STRAP = 4'h3;
    localparam logic [NUM_CH-1:0] ZERO_MASK = 4'h0;

    typedef enum logic {ST_STRAP, ST_RUN} mpps_state_type;

    typedef logic [NUM_CH-1:0][SMP_W-1:0] mpps_smp_vec_type;

    typedef struct packed {
        logic [2:0] active_count;
        logic [NUM_CH-1:0] active_mask;
    } mpps_mode_type;

    typedef struct packed {
        logic [SMP_W-1:0] average;
        logic [NUM_CH-1:0][ERR_W-1:0] error;
    } mpps_bal_type;

    localparam mpps_mode_type MODE_RESET = '{active_count: MODE_FOUR, active_mask: MASK_FOUR};

endpackage

// ---- design/mpps_bal_filter.sv ----
// First-order low-pass filter for one channel's balance error
`timescale 1ns/1ps
`default_nettype none
module mpps_bal_filter
    import mpps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic update,
    input wire logic signed [mpps_pkg::ERR_W-1:0] err_in,
    output logic signed [mpps_pkg::ERR_W-1:0] corr_ff
);

    logic signed [ERR_W:0] diff;
    logic signed [ERR_W:0] step;
    logic signed [ERR_W:0] sum;
    logic signed [ERR_W-1:0] nxt_corr;
    logic signed [ERR_W:0] step_down;
    logic signed [ERR_W:0] step_up;
    localparam logic signed [ERR_W:0] ROUND_UP = (ERR_W + 1)'((1 << FILT_SHIFT) - 1);

    // One extra bit so the difference of two signed errors cannot wrap
    assign diff = {err_in[ERR_W-1], err_in} - {corr_ff[ERR_W-1], corr_ff};
    // Floor alone would leave corrections below the error stuck short of it; round away from zero
    assign step_down = diff >>> FILT_SHIFT;
    assign step_up = (diff + ROUND_UP) >>> FILT_SHIFT;
    assign step = diff[ERR_W] ? step_down : step_up;
    assign sum = {corr_ff[ERR_W-1], corr_ff} + step;
    assign nxt_corr = !enable ? '0 : (update ? sum[ERR_W-1:0] : corr_ff);

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            corr_ff <= '0;
        end
        else
        begin
            corr_ff <= nxt_corr;
        end
    end

endmodule
`default_nettype wire

// ---- design/mpps_sequencer.sv ----
// Phase sequencer, sample-and-hold and current balance for up to four channels
`timescale 1ns/1ps
`default_nettype none
module mpps_sequencer
    import mpps_pkg::*;
#(
    // Must be a multiple of twelve so every fractional offset is exact
    parameter int PERIOD_CYC = mpps_pkg::SW_PERIOD_CYC
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [mpps_pkg::LVL_W-1:0] error_amp_level,
    input wire mpps_pkg::mpps_smp_vec_type current_sense_input,
    input wire logic channel3_strap_in,
    input wire logic channel4_strap_in,
    output logic [mpps_pkg::NUM_CH-1:0] channel_drive_out,
    output logic [mpps_pkg::NUM_CH-1:0] channel_drive_oe,
    output logic [mpps_pkg::NUM_CH-1:0] sample_window_out,
    output mpps_pkg::mpps_smp_vec_type held_sample_out,
    output mpps_pkg::mpps_bal_type balance_out,
    output mpps_pkg::mpps_mode_type mode_out
);

    // ======================================================================
    // Derived phase points
    localparam logic [PH_W-1:0] PER_LAST = PH_W'(PERIOD_CYC - 1);
    localparam logic [PH_W-1:0] QUARTER = PH_W'(PERIOD_CYC / 4);
    localparam logic [PH_W-1:0] THIRD = PH_W'(PERIOD_CYC / 3);
    localparam logic [PH_W-1:0] HALF = PH_W'(PERIOD_CYC / 2);
    localparam logic [PH_W-1:0] SIXTH = PH_W'(PERIOD_CYC / 6);
    localparam logic [PH_W-1:0] WIN_END = PH_W'(PERIOD_CYC / 6 + PERIOD_CYC / 3);
    localparam logic [PH_W-1:0] PH_ZERO = '0;
    localparam logic [PH_W-1:0] PH_ONE = PH_W'(1);
    localparam logic signed [RAMP_W-1:0] RAMP_TOP = RAMP_W'(PERIOD_CYC);
    localparam logic [STRAP_CNT_W-1:0] STRAP_LAST = STRAP_CNT_W'(STRAP_WAIT - 1);

    // Phase of one channel relative to its termination point, modulo the period
    function automatic logic [PH_W-1:0] rel_phase(input logic [PH_W-1:0] ph, input logic [PH_W-1:0] off);
        logic [PH_W-1:0] res;
        res = (ph >= off) ? (ph - off) : (ph + PH_W'(PERIOD_CYC) - off);
        return res;
    endfunction

    // ======================================================================
    // Strap capture and period counter
    logic s3_meta_ff;
    logic s3_sync_ff;
    logic s4_meta_ff;
    logic s4_sync_ff;
    mpps_state_type state_ff;
    mpps_state_type nxt_state;
    logic [STRAP_CNT_W-1:0] strap_cnt_ff;
    logic [STRAP_CNT_W-1:0] nxt_strap_cnt;
    mpps_mode_type mode_ff;
    mpps_mode_type nxt_mode;
    mpps_mode_type strap_mode;
    logic [PH_W-1:0] phase_ff;
    logic [PH_W-1:0] nxt_phase;
    logic running;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s3_meta_ff <= 1'b0;
            s3_sync_ff <= 1'b0;
            s4_meta_ff <= 1'b0;
            s4_sync_ff <= 1'b0;
        end
        else
        begin
            s3_meta_ff <= channel3_strap_in;
            s3_sync_ff <= s3_meta_ff;
            s4_meta_ff <= channel4_strap_in;
            s4_sync_ff <= s4_meta_ff;
        end
    end

    // Channel 3 strap outranks channel 4; no strap keeps four channels
    assign strap_mode = s3_sync_ff ? mpps_mode_type'{active_count: MODE_TWO, active_mask: MASK_TWO} :
                        s4_sync_ff ? mpps_mode_type'{active_count: MODE_THREE, active_mask: MASK_THREE} :
                        mpps_mode_type'{active_count: MODE_FOUR, active_mask: MASK_FOUR};

    assign running = (state_ff == ST_RUN);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_strap_cnt = strap_cnt_ff;
        nxt_mode = mode_ff;
        case (state_ff)
            ST_STRAP:
            begin
                nxt_strap_cnt = strap_cnt_ff + STRAP_CNT_W'(1);
                if (strap_cnt_ff == STRAP_LAST)
                begin
                    nxt_mode = strap_mode;
                    nxt_state = ST_RUN;
                end
            end
            default:
            begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    // Single counter serves every channel; offsets are fixed fractions of it
    assign nxt_phase = !running ? PH_ZERO : ((phase_ff == PER_LAST) ? PH_ZERO : phase_ff + PH_ONE);

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff <= ST_STRAP;
            strap_cnt_ff <= '0;
            mode_ff <= MODE_RESET;
            phase_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            strap_cnt_ff <= nxt_strap_cnt;
            mode_ff <= nxt_mode;
            phase_ff <= nxt_phase;
        end
    end

    // ======================================================================
    // Per-channel pulse generation and sampling
    logic [NUM_CH-1:0] drive_ff;
    logic [NUM_CH-1:0] nxt_drive;
    logic [NUM_CH-1:0] oe_ff;
    logic [NUM_CH-1:0] nxt_oe;
    logic [NUM_CH-1:0] win_ff;
    logic [NUM_CH-1:0] win_open;
    logic [NUM_CH-1:0] win_close;
    logic [NUM_CH-1:0] term_edge;
    logic [NUM_CH-1:0][PH_W-1:0] ch_phase;
    logic [NUM_CH-1:0][ERR_W-1:0] corr;
    mpps_smp_vec_type track_ff;
    mpps_smp_vec_type held_ff;
    mpps_bal_type bal_ff;
    mpps_bal_type nxt_bal;

    assign nxt_oe = running ? mode_ff.active_mask : OE_STRAP;

    generate
        for (genvar i = 0; i < NUM_CH; i++)
        begin : g_ch
            // Highest active channel terminates first, then each lower one later
            localparam logic [PH_W-1:0] OFF4 = PH_W'((NUM_CH - 1 - i) * (PERIOD_CYC / 4));
            localparam logic [PH_W-1:0] OFF3 = (i < 3) ? PH_W'((2 - i) * (PERIOD_CYC / 3)) : PH_ZERO;
            localparam logic [PH_W-1:0] OFF2 = (i < 2) ? PH_W'((1 - i) * (PERIOD_CYC / 2)) : PH_ZERO;
            logic [PH_W-1:0] off_sel;
            logic signed [RAMP_W-1:0] mod_level;
            logic signed [RAMP_W-1:0] ramp_sum;
            logic active;
            logic rise;

            assign active = running & mode_ff.active_mask[i];
            assign off_sel = (mode_ff.active_count == MODE_FOUR) ? OFF4 :
                             (mode_ff.active_count == MODE_THREE) ? OFF3 : OFF2;
            assign ch_phase[i] = rel_phase(phase_ff, off_sel);
            assign term_edge[i] = active & (ch_phase[i] == PER_LAST);
            assign mod_level = $signed({2'b00, error_amp_level}) -
                               {{(RAMP_W - ERR_W){corr[i][ERR_W-1]}}, corr[i]};
            assign ramp_sum = mod_level + $signed(RAMP_W'(ch_phase[i]));
            // Rise blocked until the forced off third has passed
            assign rise = active & (ch_phase[i] >= THIRD) & (mod_level > 0) & (ramp_sum >= RAMP_TOP);
            assign nxt_drive[i] = term_edge[i] ? 1'b0 : (active & (drive_ff[i] | rise));
            // Window shuts at one half (sixth plus third) or on rise
            assign win_open[i] = active & !nxt_drive[i] & (ch_phase[i] >= SIXTH) & (ch_phase[i] < WIN_END);
            assign win_close[i] = win_ff[i] & !win_open[i];

            always_ff @(posedge clk_sys or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    drive_ff[i] <= 1'b0;
                    win_ff[i] <= 1'b0;
                    track_ff[i] <= '0;
                    held_ff[i] <= '0;
                end
                else
                begin
                    drive_ff[i] <= nxt_drive[i];
                    win_ff[i] <= win_open[i];
                    track_ff[i] <= win_open[i] ? current_sense_input[i] : track_ff[i];
                    held_ff[i] <= !active ? '0 : (win_close[i] ? track_ff[i] : held_ff[i]);
                end
            end

            assign nxt_bal.error[i] = active ? ({1'b0, held_ff[i]} - {1'b0, bal_ff.average}) : '0;

            mpps_bal_filter u_filter (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .enable(active),
                .update(term_edge[i]),
                .err_in(bal_ff.error[i]),
                .corr_ff(corr[i])
            );

            chk_fall_term : assert property (@(posedge clk_sys) disable iff (sys_rst)
                $fell(drive_ff[i]) |-> ch_phase[i] == PH_ZERO)
                else $error("channel fell away from its termination point");
            chk_forced_off : assert property (@(posedge clk_sys) disable iff (sys_rst)
                drive_ff[i] |-> ch_phase[i] > THIRD)
                else $error("channel high inside forced off time");
            chk_window_span : assert property (@(posedge clk_sys) disable iff (sys_rst)
                win_ff[i] |-> !drive_ff[i] && ch_phase[i] > SIXTH && ch_phase[i] <= WIN_END)
                else $error("sample window outside its span");
            chk_hold_stable : assert property (@(posedge clk_sys) disable iff (sys_rst)
                $changed(held_ff[i]) && $past(active) |-> $past(win_close[i]))
                else $error("held sample changed without a window close");
            chk_off_channel : assert property (@(posedge clk_sys) disable iff (sys_rst)
                running && !mode_ff.active_mask[i] |=> !oe_ff[i] && !drive_ff[i] && held_ff[i] == '0)
                else $error("disabled channel still active");
        end
    endgenerate

    // ======================================================================
    // Averaging over active channels
    logic [SMP_W+1:0] sum_act;
    logic [SMP_W+1:0] avg_full;

    always_comb
    begin
        sum_act = '0;
        for (int k = 0; k < NUM_CH; k++)
        begin
            sum_act = sum_act + (SMP_W + 2)'(held_ff[k]);
        end
    end

    // Inactive held samples are forced to zero, so the plain sum is safe
    assign avg_full = (mode_ff.active_count == MODE_FOUR) ? (sum_act >> 2) :
                      (mode_ff.active_count == MODE_THREE) ? (SMP_W + 2)'(sum_act / 3) : (sum_act >> 1);
    assign nxt_bal.average = avg_full[SMP_W-1:0];

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bal_ff <= '0;
            oe_ff <= OE_STRAP;
        end
        else
        begin
            bal_ff <= nxt_bal;
            oe_ff <= nxt_oe;
        end
    end

    // ======================================================================
    // Outputs
    assign channel_drive_out = drive_ff;
    assign channel_drive_oe = oe_ff;
    assign sample_window_out = win_ff;
    assign held_sample_out = held_ff;
    assign balance_out = bal_ff;
    assign mode_out = mode_ff;

    // ======================================================================
    // Checks on mode selection, phase relations between channels and the two channel average
    sequence four_ch_top_wrap;
        running && mode_ff.active_count == MODE_FOUR && ch_phase[3] == PH_ZERO;
    endsequence

    chk_default_four : assert property (@(posedge clk_sys) disable iff (sys_rst)
        state_ff == ST_STRAP && nxt_state == ST_RUN && !s3_sync_ff && !s4_sync_ff
        |=> mode_ff.active_count == MODE_FOUR)
        else $error("unstrapped part not in four channel mode");
    chk_quarter_order : assert property (@(posedge clk_sys) disable iff (sys_rst)
        four_ch_top_wrap |-> ch_phase[2] == PER_LAST - QUARTER + PH_ONE && ch_phase[0] == QUARTER)
        else $error("four channel spacing wrong");
    chk_third_order : assert property (@(posedge clk_sys) disable iff (sys_rst)
        running && mode_ff.active_count == MODE_THREE && ch_phase[2] == PH_ZERO
        |-> ch_phase[1] == PER_LAST - THIRD + PH_ONE && ch_phase[0] == THIRD)
        else $error("three channel spacing wrong");
    chk_half_pair : assert property (@(posedge clk_sys) disable iff (sys_rst)
        running && mode_ff.active_count == MODE_TWO && ch_phase[0] == PH_ZERO |-> ch_phase[1] == HALF)
        else $error("two channel spacing wrong");
    chk_average_sum : assert property (@(posedge clk_sys) disable iff (sys_rst)
        running && mode_ff.active_count == MODE_TWO
        |=> bal_ff.average == SMP_W'(({1'b0, $past(held_ff[0])} + {1'b0, $past(held_ff[1])}) >> 1))
        else $error("two channel average wrong");

endmodule
`default_nettype wire

// ---- bench/mpps_gate_driver_model.sv ----
// Gate driver and power stage model on the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module mpps_gate_driver_model
    import mpps_pkg::*;
(
    input wire logic [mpps_pkg::NUM_CH-1:0] channel_drive_out,
    input wire logic [mpps_pkg::NUM_CH-1:0] channel_drive_oe,
    input wire logic tie3_high,
    input wire logic tie4_high,
    input wire mpps_pkg::mpps_smp_vec_type phase_current,
    output logic channel3_pin,
    output logic channel4_pin,
    output mpps_pkg::mpps_smp_vec_type sense_out
);
    logic [NUM_CH-1:0] pin_level;
    // ======================================================================
    // Pin levels: undriven pins fall to their strap, or are pulled low
    assign pin_level[1:0] = channel_drive_out[1:0] & channel_drive_oe[1:0];
    assign pin_level[2] = channel_drive_oe[2] ? channel_drive_out[2] : tie3_high;
    assign pin_level[3] = channel_drive_oe[3] ? channel_drive_out[3] : tie4_high;
    assign channel3_pin = pin_level[2];
    assign channel4_pin = pin_level[3];
    // Sense is only valid while the low side conducts; garbage otherwise
    always_comb
    begin
        for (int c = 0; c < NUM_CH; c++)
        begin
            sense_out[c] = pin_level[c] ? ~phase_current[c] : phase_current[c];
        end
    end
endmodule
`default_nettype wire

// ---- bench/multiphase_pwm_phase_sequencer_test.sv ----
// Self-checking bench for the multiphase pulse sequencer
`timescale 1ns/1ps
`default_nettype none
module multiphase_pwm_phase_sequencer_test;
    import mpps_pkg::*;
    // ======================================================================
    // Setup: short period keeps the run brief, offsets derive from it
    localparam int P = 24;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [LVL_W-1:0] level = '0;
    logic tie3 = 1'b0;
    logic tie4 = 1'b0;
    logic s3;
    logic s4;
    mpps_smp_vec_type cur = '0;
    mpps_smp_vec_type sense;
    mpps_smp_vec_type held;
    logic [NUM_CH-1:0] drv;
    logic [NUM_CH-1:0] oe;
    logic [NUM_CH-1:0] win;
    logic [NUM_CH-1:0] drv_prev = '0;
    mpps_bal_type bal;
    mpps_mode_type mode;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    int fall_t [NUM_CH];

    always #5 clk_sys = ~clk_sys;

    mpps_sequencer #(.PERIOD_CYC(P)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .error_amp_level(level),
        .current_sense_input(sense), .channel3_strap_in(s3), .channel4_strap_in(s4), .channel_drive_out(drv),
        .channel_drive_oe(oe), .sample_window_out(win), .held_sample_out(held), .balance_out(bal), .mode_out(mode));

    mpps_gate_driver_model drivers (.channel_drive_out(drv), .channel_drive_oe(oe), .tie3_high(tie3),
        .tie4_high(tie4), .phase_current(cur), .channel3_pin(s3), .channel4_pin(s4), .sense_out(sense));

    always @(posedge clk_sys)
    begin
        drv_prev <= drv;
        cyc <= cyc + 1;
    end

    always @(negedge clk_sys)
    begin
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (drv_prev[c] === 1'b1 && drv[c] === 1'b0)
                fall_t[c] = cyc;
        end
    end

    // ======================================================================
    // Shared tasks
    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Straps stay put from reset on, since the mode latches after release
    task automatic start_up(input logic t3, input logic t4);
        @(negedge clk_sys);
        sys_rst = 1'b1;
        tie3 = t3;
        tie4 = t4;
        repeat (12) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (STRAP_WAIT + 3 * P) @(negedge clk_sys);
    endtask

    // One full cycle of channel c, from its falling edge
    task automatic watch(input int c, output int lo, output int hi, output int wo, output int wl);
        int n;
        n = 0;
        lo = 0;
        hi = 0;
        wo = -1;
        wl = 0;
        while (!(drv_prev[c] === 1'b1 && drv[c] === 1'b0))
        begin
            @(negedge clk_sys);
            n++;
            if (n > 3 * P)
            begin
                check(1'b0, "no falling edge");
                wrap_up();
            end
        end
        for (int i = 0; i < P; i++)
        begin
            if (drv[c] === 1'b1)
                hi++;
            else if (hi == 0)
                lo++;
            if (win[c] === 1'b1)
            begin
                wl++;
                if (wo < 0)
                    wo = i;
            end
            @(negedge clk_sys);
        end
    endtask

    // ======================================================================
    // Scenarios
    task automatic test_modes();
        int n_exp [4] = '{4, 3, 2, 2};
        logic [3:0] m_exp [4] = '{4'hf, 4'h7, 4'h3, 4'h3};
        logic stray;
        // Pair sum above the sample range exercises the average width
        cur = {10'h190, 10'h12c, 10'h2bc, 10'h3e8};
        for (int k = 0; k < 4; k++)
        begin
            start_up(k[1], k[0]);
            level = 12'hfff;
            stray = 1'b0;
            repeat (2 * P)
            begin
                @(negedge clk_sys);
                stray = stray | (|(drv & ~m_exp[k]));
            end
            check(mode.active_count === 3'(n_exp[k]) && mode.active_mask === m_exp[k], "mode");
            check(oe === m_exp[k] && stray === 1'b0, "inactive channel drives");
            for (int i = 0; i + 1 < n_exp[k]; i++)
                check(((fall_t[i] - fall_t[i + 1]) % P + P) % P == P / n_exp[k], "fall spacing");
            if (n_exp[k] == 2)
                check(bal.average === 10'h352, "two channel average");
        end
        $display("test modes done");
    endtask

    task automatic test_timing();
        int lo, hi, wo, wl;
        int lv [2] = '{P / 3, P / 2};
        // Zero currents keep every correction at zero, so rise points are exact
        cur = '0;
        start_up(1'b0, 1'b0);
        level = 12'hfff;
        watch(0, lo, hi, wo, wl);
        check(lo == P / 3 + 1 && lo + hi == P, "forced off");
        check(wo == P / 6 + 1 && wl == P / 6, "window cut by rise");
        for (int k = 0; k < 2; k++)
        begin
            level = 12'(lv[k]);
            watch(1, lo, hi, wo, wl);
            watch(1, lo, hi, wo, wl);
            check(hi == lv[k] - 1 && lo + hi == P, "rise point");
            check(wo == P / 6 + 1 && wl == P / 3, "window full");
        end
        level = '0;
        repeat (P) @(negedge clk_sys);
        hi = 0;
        repeat (2 * P)
        begin
            @(negedge clk_sys);
            hi += (drv !== 4'h0);
        end
        check(hi == 0, "drive at zero level");
        $display("test timing done");
    endtask

    task automatic test_hold();
        int n;
        cur = {10'h190, 10'h12c, 10'h0c8, 10'h064};
        level = 12'hfff;
        repeat (3 * P) @(negedge clk_sys);
        for (int c = 0; c < NUM_CH; c++)
        begin
            check(held[c] === cur[c], "held value");
            check(bal.error[c] === 11'(cur[c]) - 11'h0fa, "balance error");
        end
        check(bal.average === 10'h0fa, "average");
        n = 0;
        while (win[0] !== 1'b1 && n < 2 * P)
        begin
            @(negedge clk_sys);
            n++;
        end
        while (win[0] === 1'b1 && n < 2 * P)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 2 * P)
        begin
            check(1'b0, "window wait");
            wrap_up();
        end
        cur[0] = 10'h020;
        repeat (P - 2) @(negedge clk_sys);
        check(held[0] === 10'h064, "held kept");
        repeat (P) @(negedge clk_sys);
        check(held[0] === 10'h020 && bal.average === 10'h0e9, "held replaced");
        $display("test hold done");
    endtask

    task automatic test_three();
        start_up(1'b0, 1'b1);
        cur = {10'h190, 10'h12c, 10'h0c8, 10'h064};
        repeat (3 * P) @(negedge clk_sys);
        check(held[3] === 10'h000 && bal.error[3] === 11'h000, "excluded channel");
        check(bal.average === 10'h0c8 && bal.error[2] === 11'h064, "three channel average");
        $display("test three done");
    endtask

    task automatic test_balance();
        int h [NUM_CH];
        int lo, wo, wl;
        start_up(1'b0, 1'b0);
        cur = {10'h102, 10'h0fa, 10'h0fa, 10'h0f2};
        level = 12'(P / 2 + 2);
        repeat (40 * P) @(negedge clk_sys);
        for (int c = 0; c < NUM_CH; c++)
            watch(c, lo, h[c], wo, wl);
        check(h[1] == P / 2 + 1 && h[2] == h[1], "balanced width");
        check(h[3] < h[1] && h[0] > h[1], "trim direction");
        $display("test balance done");
    endtask

    initial
    begin
        test_modes();
        test_timing();
        test_hold();
        test_three();
        test_balance();
        wrap_up();
    end
endmodule
`default_nettype wire
